//--- usf_pkg.sv
package usf_pkg;
    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_FORMAT      = 16'h7050;
    localparam logic [15:0] IDX_CONTROL_ONE = 16'h7051;
    localparam logic [15:0] IDX_CONTROL_TWO = 16'h7054;
    localparam logic [15:0] IDX_RX_STATUS   = 16'h7055;
    localparam logic [15:0] IDX_RX_BUFFER   = 16'h7057;
    localparam int          ADDR_W          = 17;

    // receiver_status fields
    localparam int STS_ERROR   = 7;
    localparam int STS_READY   = 6;
    localparam int STS_BREAK   = 5;
    localparam int STS_FRAME   = 4;
    localparam int STS_OVERRUN = 3;
    localparam int STS_PARITY  = 2;
    localparam int STS_WAKE    = 1;

    // control_one, control_two and format fields
    localparam int CTL1_ERR_IRQ_EN = 6;
    localparam int CTL1_SOFT_RESET = 5;
    localparam int CTL1_SLEEP      = 2;
    localparam int CTL2_RX_BRK_EN  = 1;
    localparam int FMT_PARITY_EN   = 5;
    localparam int FMT_PARITY_EVEN = 6;

    // reset values
    localparam logic [7:0] STATUS_RESET      = 8'h00;
    localparam logic [7:0] CONTROL_ONE_RESET = 8'h00;
    localparam logic [7:0] CONTROL_TWO_RESET = 8'h00;
    localparam logic [7:0] FORMAT_RESET      = 8'h00;
    localparam logic [7:0] BUFFER_RESET      = 8'h00;

    // break length in bit times
    localparam logic [3:0] BREAK_BITS = 4'ha;

    typedef enum logic {
        USF_BRK_IDLE,
        USF_BRK_COUNT
    } usf_brk_state_t;

    function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
        return {idx[14:0], 2'b00};
    endfunction
endpackage

//--- usf_break_watch.sv
`timescale 1ns/10ps
module usf_break_watch (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic arm,
    input  wire logic serial_receive_line,
    input  wire logic bit_tick,
    output logic      detect
);
    usf_pkg::usf_brk_state_t state;
    logic [3:0]              low_bits;

    wire       counting  = (state == usf_pkg::USF_BRK_COUNT);
    wire       tick_low  = counting & bit_tick & ~serial_receive_line;
    wire [3:0] next_bits = low_bits + 4'h1;
    wire       reached   = tick_low & (next_bits == usf_pkg::BREAK_BITS);

    // low-time counter from the missing stop bit onward
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state    <= usf_pkg::USF_BRK_IDLE;
            low_bits <= 4'h0;
            detect   <= 1'b0;
        end else begin
            detect <= reached;
            unique case (state)
                usf_pkg::USF_BRK_IDLE: begin
                    low_bits <= 4'h0;
                    if (arm) begin
                        state <= usf_pkg::USF_BRK_COUNT;
                    end
                end
                usf_pkg::USF_BRK_COUNT: begin
                    if (serial_receive_line || reached) begin
                        state    <= usf_pkg::USF_BRK_IDLE;
                        low_bits <= 4'h0;
                    end else if (tick_low) begin
                        low_bits <= next_bits;
                    end
                end
            endcase
        end
    end
endmodule // usf_break_watch

//--- usf_rx_status.sv
`timescale 1ns/10ps
//Behaviour
// - flags update when a character is stored
// - error bit is OR of four errors
// - error flag with enable requests interrupt
// - error flag clears only by resets
// - ready flag set on new character
// - ready clears on buffer read or reset
// - break after ten low bit times
// - break interrupts and never loads buffer
// - break interrupt works while sleeping
// - break clears only by resets
// - missing stop bit sets framing error
// - only first stop bit is checked
// - framing error clears only by resets
// - status register read-only, zero after reset
// - overwrite before read sets overrun
// - parity mismatch sets parity error flag
module usf_rx_status (
    input  wire logic                       sys_clk,
    input  wire logic                       rst,
    input  wire logic [usf_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [31:0]                avs_writedata,
    output logic [31:0]                     avs_readdata,
    output logic                            avs_waitrequest,
    input  wire logic                       serial_receive_line,
    input  wire logic                       bit_tick,
    input  wire logic                       char_done,
    input  wire logic [7:0]                 char_data,
    input  wire logic                       char_addr_bit,
    input  wire logic                       char_parity_bit,
    input  wire logic                       char_stop_ok,
    output logic                            rx_irq,
    output logic                            err_irq
);
    logic [7:0] format;
    logic [7:0] control_one;
    logic [7:0] control_two;
    logic [7:0] receive_buffer;
    logic       rx_ready_flag;
    logic       break_detect_flag;
    logic       framing_error_flag;
    logic       overrun_flag;
    logic       parity_error_flag;
    logic       brk_detect;

    // bus decode
    wire req     = avs_read | avs_write;
    wire rd_acc  = avs_read & ~avs_waitrequest;
    wire wr_acc  = avs_write & ~avs_waitrequest;
    wire hit_fmt = (avs_address == usf_pkg::byte_addr(usf_pkg::IDX_FORMAT));
    wire hit_c1  = (avs_address == usf_pkg::byte_addr(usf_pkg::IDX_CONTROL_ONE));
    wire hit_c2  = (avs_address == usf_pkg::byte_addr(usf_pkg::IDX_CONTROL_TWO));
    wire hit_sts = (avs_address == usf_pkg::byte_addr(usf_pkg::IDX_RX_STATUS));
    wire hit_buf = (avs_address == usf_pkg::byte_addr(usf_pkg::IDX_RX_BUFFER));

    // control decode
    wire mod_rst     = rst | ~control_one[usf_pkg::CTL1_SOFT_RESET];
    wire sleep       = control_one[usf_pkg::CTL1_SLEEP];
    wire err_en      = control_one[usf_pkg::CTL1_ERR_IRQ_EN];
    wire rx_brk_en   = control_two[usf_pkg::CTL2_RX_BRK_EN];
    wire par_en      = format[usf_pkg::FMT_PARITY_EN];
    wire par_even    = format[usf_pkg::FMT_PARITY_EVEN];
    wire buffer_read = rd_acc & hit_buf;

    // character acceptance; blocked after a break until reset
    wire load_ok     = char_done & ~break_detect_flag
                     & (~sleep | char_addr_bit);
    wire stop_bad    = ~char_stop_ok;
    wire arm_break   = char_done & stop_bad & ~break_detect_flag;
    wire parity_bad  = par_en
                     & ((^{char_data, char_addr_bit, char_parity_bit}) == par_even);
    wire rx_error    = break_detect_flag | framing_error_flag
                     | overrun_flag | parity_error_flag;

    // next flag values; a set wins over a same-cycle clear
    wire next_ready   = load_ok | (rx_ready_flag & ~buffer_read);
    wire next_overrun = overrun_flag | (load_ok & rx_ready_flag & ~buffer_read);
    wire next_frame   = framing_error_flag | (load_ok & stop_bad);
    wire next_parity  = parity_error_flag | (load_ok & parity_bad);
    wire next_break   = break_detect_flag | brk_detect;

    wire [7:0] status_word = {rx_error, rx_ready_flag, break_detect_flag,
                              framing_error_flag, overrun_flag, parity_error_flag,
                              1'b0, 1'b0};
    wire [7:0] rd_value = hit_sts ? status_word :
                          hit_buf ? receive_buffer :
                          hit_c1  ? control_one :
                          hit_c2  ? control_two :
                          hit_fmt ? format : 8'h00;

    usf_break_watch u_break (
        .sys_clk             (sys_clk),
        .rst                 (mod_rst),
        .arm                 (arm_break),
        .serial_receive_line (serial_receive_line),
        .bit_tick            (bit_tick),
        .detect              (brk_detect)
    );

    // bus slave: one wait cycle, then the access completes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= ~(req & avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                avs_readdata <= {24'h00_0000, rd_value};
            end
        end
    end

    // software-written controls
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            format      <= usf_pkg::FORMAT_RESET;
            control_one <= usf_pkg::CONTROL_ONE_RESET;
            control_two <= usf_pkg::CONTROL_TWO_RESET;
        end else if (wr_acc) begin
            if (hit_fmt) format <= avs_writedata[7:0];
            if (hit_c1) control_one <= avs_writedata[7:0];
            if (hit_c2) control_two <= avs_writedata[7:0];
        end
    end

    // status flags, cleared by either reset
    always_ff @(posedge sys_clk) begin
        if (mod_rst) begin
            rx_ready_flag      <= usf_pkg::STATUS_RESET[usf_pkg::STS_READY];
            break_detect_flag  <= usf_pkg::STATUS_RESET[usf_pkg::STS_BREAK];
            framing_error_flag <= usf_pkg::STATUS_RESET[usf_pkg::STS_FRAME];
            overrun_flag       <= usf_pkg::STATUS_RESET[usf_pkg::STS_OVERRUN];
            parity_error_flag  <= usf_pkg::STATUS_RESET[usf_pkg::STS_PARITY];
        end else begin
            rx_ready_flag      <= next_ready;
            break_detect_flag  <= next_break;
            framing_error_flag <= next_frame;
            overrun_flag       <= next_overrun;
            parity_error_flag  <= next_parity;
        end
    end

    // receive buffer, never loaded by a break
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            receive_buffer <= usf_pkg::BUFFER_RESET;
        end else if (load_ok) begin
            receive_buffer <= char_data;
        end
    end

    // level interrupt requests
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rx_irq  <= 1'b0;
            err_irq <= 1'b0;
        end else begin
            rx_irq  <= (rx_ready_flag | break_detect_flag) & rx_brk_en;
            err_irq <= rx_error & err_en;
        end
    end

    // checks
    property p_err_or;
        @(posedge sys_clk) disable iff (rst)
        (avs_read && avs_waitrequest && hit_sts)
            |=> avs_readdata[usf_pkg::STS_ERROR] == ($past(break_detect_flag)
                | $past(framing_error_flag) | $past(overrun_flag)
                | $past(parity_error_flag));
    endproperty
    a_err_or: assert property (p_err_or) else $error("error bit not OR of flags");

    property p_err_irq;
        @(posedge sys_clk) disable iff (rst)
        (rx_error && err_en) |=> err_irq;
    endproperty
    a_err_irq: assert property (p_err_irq) else $error("error irq missing");

    property p_err_hold;
        @(posedge sys_clk) disable iff (rst)
        (rx_error && !mod_rst) |=> rx_error;
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("error flag cleared");

    property p_ready_set;
        @(posedge sys_clk) disable iff (rst)
        (load_ok && !mod_rst) |=> rx_ready_flag && receive_buffer == $past(char_data);
    endproperty
    a_ready_set: assert property (p_ready_set) else $error("ready not set");

    property p_ready_clr;
        @(posedge sys_clk) disable iff (rst)
        $fell(rx_ready_flag) |-> $past(buffer_read) || $past(mod_rst);
    endproperty
    a_ready_clr: assert property (p_ready_clr) else $error("ready dropped early");

    property p_break_set;
        @(posedge sys_clk) disable iff (rst)
        (brk_detect && !mod_rst) |=> break_detect_flag;
    endproperty
    a_break_set: assert property (p_break_set) else $error("break not flagged");

    property p_break_noload;
        @(posedge sys_clk) disable iff (rst)
        break_detect_flag |=> receive_buffer == $past(receive_buffer);
    endproperty
    a_break_noload: assert property (p_break_noload) else $error("load after break");

    property p_break_sleep;
        @(posedge sys_clk) disable iff (rst)
        (break_detect_flag && rx_brk_en && sleep) |=> rx_irq;
    endproperty
    a_break_sleep: assert property (p_break_sleep) else $error("break irq lost");

    property p_break_hold;
        @(posedge sys_clk) disable iff (rst)
        (break_detect_flag && !mod_rst) |=> break_detect_flag;
    endproperty
    a_break_hold: assert property (p_break_hold) else $error("break cleared");

    property p_frame;
        @(posedge sys_clk) disable iff (rst)
        (load_ok && !char_stop_ok && !mod_rst) |=> framing_error_flag;
    endproperty
    a_frame: assert property (p_frame) else $error("framing not flagged");

    property p_frame_clr;
        @(posedge sys_clk) disable iff (rst)
        mod_rst |=> !framing_error_flag && status_word == usf_pkg::STATUS_RESET;
    endproperty
    a_frame_clr: assert property (p_frame_clr) else $error("flags survive reset");

    property p_overrun;
        @(posedge sys_clk) disable iff (rst)
        (load_ok && rx_ready_flag && !buffer_read && !mod_rst) |=> overrun_flag;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun missed");

    property p_parity;
        @(posedge sys_clk) disable iff (rst)
        (!par_en && !parity_error_flag) |=> !parity_error_flag;
    endproperty
    a_parity: assert property (p_parity) else $error("parity set while off");

    property p_irq_level;
        @(posedge sys_clk) disable iff (rst)
        (rx_ready_flag && rx_brk_en) [*2] |=> rx_irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("rx irq not level");

    c_load: cover property (@(posedge sys_clk) disable iff (rst) load_ok ##1 buffer_read);
    c_break: cover property (@(posedge sys_clk) disable iff (rst) brk_detect);
    c_overrun: cover property (@(posedge sys_clk) disable iff (rst) $rose(overrun_flag));
    c_parity: cover property (@(posedge sys_clk) disable iff (rst) $rose(parity_error_flag));
endmodule // usf_rx_status

//--- usf_remote_tx.sv
`timescale 1ns/10ps
module usf_remote_tx (
    input  wire logic       sys_clk,
    output logic            serial_receive_line,
    output logic            bit_tick,
    output logic            char_done,
    output logic [7:0]      char_data,
    output logic            char_addr_bit,
    output logic            char_parity_bit,
    output logic            char_stop_ok
);
    initial begin
        serial_receive_line = 1'b1;
        bit_tick = 1'b0;
        char_done = 1'b0;
        {char_data, char_addr_bit, char_parity_bit, char_stop_ok} = 11'h001;
    end

    // one character, line low from a bad stop bit for a number of bit times
    task automatic send(input logic [7:0] d, input logic a, input logic p,
                        input logic s, input int lows);
        @(posedge sys_clk);
        char_done <= 1'b1;
        {char_data, char_addr_bit, char_parity_bit, char_stop_ok} <= {d, a, p, s};
        serial_receive_line <= s;
        @(posedge sys_clk);
        char_done <= 1'b0;
        {char_data, char_addr_bit, char_parity_bit, char_stop_ok} <= ~{d, a, p, s};
        repeat (lows) begin
            repeat (3) @(posedge sys_clk);
            bit_tick <= 1'b1;
            @(posedge sys_clk);
            bit_tick <= 1'b0;
        end
        serial_receive_line <= 1'b1;
    endtask
endmodule // usf_remote_tx

//--- usf_rx_status_test.sv
`timescale 1ns/10ps
module usf_rx_status_test;
    localparam logic [15:0] STS = usf_pkg::IDX_RX_STATUS;
    localparam logic [15:0] BUF = usf_pkg::IDX_RX_BUFFER;
    localparam logic [15:0] C1  = usf_pkg::IDX_CONTROL_ONE;
    localparam logic [15:0] C2  = usf_pkg::IDX_CONTROL_TWO;
    localparam logic [15:0] FMT = usf_pkg::IDX_FORMAT;

    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [16:0] avs_address = 17'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        serial_receive_line, bit_tick, char_done;
    logic [7:0]  char_data;
    logic        char_addr_bit, char_parity_bit, char_stop_ok;
    logic        rx_irq, err_irq;
    int          mismatches = 0;
    int          tests_run = 0;
    int          cycles = 0;

    usf_rx_status usf_rx_status_i (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .serial_receive_line(serial_receive_line), .bit_tick(bit_tick),
        .char_done(char_done), .char_data(char_data), .char_addr_bit(char_addr_bit),
        .char_parity_bit(char_parity_bit), .char_stop_ok(char_stop_ok),
        .rx_irq(rx_irq), .err_irq(err_irq));

    usf_remote_tx usf_remote_tx_i (.sys_clk(sys_clk), .serial_receive_line(serial_receive_line),
        .bit_tick(bit_tick), .char_done(char_done), .char_data(char_data),
        .char_addr_bit(char_addr_bit), .char_parity_bit(char_parity_bit),
        .char_stop_ok(char_stop_ok));

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            mismatches++;
            close_out;
        end
    end

    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic chk1(input logic g, input logic e);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    // one Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d,
                       output logic [7:0] q);
        @(posedge sys_clk);
        avs_address <= {idx[14:0], 2'b00};
        avs_writedata <= {24'h0, d};
        avs_read <= ~w;
        avs_write <= w;
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, idx, d, q);
    endtask

    task automatic rd(input logic [15:0] idx, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, idx, 8'h00, q);
        chk8(q, e);
    endtask

    // module soft reset toggled
    task automatic sr;
        wr(C1, 8'h40);
        wr(C1, 8'h60);
    endtask

    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        rd(STS, 8'h00);
        wr(STS, 8'hff);
        rd(STS, 8'h00);
        rd(16'h7060, 8'h00);
        wr(C1, 8'h60);
        wr(C2, 8'h02);
        $display("test registers done");
        usf_remote_tx_i.send(8'h5a, 1'b0, 1'b0, 1'b1, 0);
        rd(STS, 8'h40);
        chk1(rx_irq, 1'b1);
        chk1(err_irq, 1'b0);
        rd(BUF, 8'h5a);
        rd(STS, 8'h00);
        chk1(rx_irq, 1'b0);
        $display("test ready done");
        usf_remote_tx_i.send(8'ha1, 1'b0, 1'b0, 1'b1, 0);
        usf_remote_tx_i.send(8'ha2, 1'b0, 1'b0, 1'b1, 0);
        rd(STS, 8'hc8);
        chk1(err_irq, 1'b1);
        rd(BUF, 8'ha2);
        rd(STS, 8'h88);
        wr(C1, 8'h20);
        repeat (2) @(posedge sys_clk);
        chk1(err_irq, 1'b0);
        sr();
        rd(STS, 8'h00);
        $display("test overrun done");
        wr(FMT, 8'h60);
        usf_remote_tx_i.send(8'h01, 1'b0, 1'b0, 1'b1, 0);
        rd(STS, 8'hc4);
        sr();
        wr(FMT, 8'h00);
        usf_remote_tx_i.send(8'h01, 1'b0, 1'b0, 1'b1, 0);
        rd(STS, 8'h40);
        rd(BUF, 8'h01);
        $display("test parity done");
        usf_remote_tx_i.send(8'h11, 1'b0, 1'b0, 1'b0, 9);
        repeat (6) @(posedge sys_clk);
        rd(STS, 8'hd0);
        rd(BUF, 8'h11);
        rd(STS, 8'h90);
        wr(C1, 8'h64);
        usf_remote_tx_i.send(8'h55, 1'b0, 1'b0, 1'b1, 0);
        rd(STS, 8'h90);
        usf_remote_tx_i.send(8'h9c, 1'b1, 1'b0, 1'b0, 10);
        repeat (6) @(posedge sys_clk);
        rd(STS, 8'hf0);
        rd(BUF, 8'h9c);
        rd(STS, 8'hb0);
        chk1(rx_irq, 1'b1);
        usf_remote_tx_i.send(8'h33, 1'b1, 1'b0, 1'b1, 0);
        rd(STS, 8'hb0);
        rd(BUF, 8'h9c);
        wr(C2, 8'h00);
        repeat (2) @(posedge sys_clk);
        chk1(rx_irq, 1'b0);
        wr(C2, 8'h02);
        sr();
        rd(STS, 8'h00);
        usf_remote_tx_i.send(8'h77, 1'b0, 1'b0, 1'b1, 0);
        rd(BUF, 8'h77);
        $display("test break done");
        close_out;
    end
endmodule // usf_rx_status_test
